//--- rtl/adcpt_pair_ctrl.sv
// converter pair trigger control: registers, pending flags, sequencer hand-off

module adcpt_pair_ctrl (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // trigger sources, same clock
  input  wire logic        globalSoftTrig,
  input  wire logic        pwmSpecialEvt,
  input  wire logic        pwmSecSpecialEvt,
  input  wire logic [7:0]  pwmPrimaryTrig,
  input  wire logic [8:0]  pwmSecondaryTrig,
  input  wire logic [7:0]  pwmCurLimTrig,
  input  wire logic        firstTimerMatch,
  input  wire logic        secondTimerMatch,
  // converter core
  input  wire logic        coreBusy,
  input  wire logic        coreDone,
  output logic             convStart,
  output logic [4:0]       convFirstInput,
  output logic [2:0]       convPairSel,
  // per-pair completion requests
  output logic [2:0]       pairIrq
);

  localparam int NP = adcpt_pkg::NPAIR;

  // pair control state
  logic [NP-1:0]      irqEn_ff;    // interrupt-request enables
  logic [NP-1:0]      pend_ff;     // pending-conversion flags
  logic [NP-1:0]      soft_ff;     // software trigger bits
  logic [NP-1:0][4:0] trigSrc_ff;  // trigger source selectors
  logic [7:0]         p3Byte_ff;   // pair 3 byte, plain storage only

  // sequencer state
  adcpt_pkg::adcpt_conv_t state_ff;  // idle or converting
  logic [NP-1:0]      inFlight_ff;   // one-hot pair being converted
  logic               convStart_ff;  // start pulse to core
  logic [4:0]         convInput_ff;  // lower input of started pair
  logic [NP-1:0]      irq_ff;        // completion request pulses

  // bus state
  logic               awHeld_ff;  // write address captured
  logic [7:0]         awAddr_ff;
  logic               wHeld_ff;   // write data captured
  logic [31:0]        wData_ff;
  logic [3:0]         wStrb_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [31:0]        rdata_ff;
  logic [1:0]         rresp_ff;

  // per-pair combinational terms
  logic [NP-1:0]      trigHit;   // selected trigger asserted
  logic [NP-1:0]      doneThis;  // this pair's conversion finished
  logic [NP-1:0]      setPend;   // pending flag is being set
  logic [NP-1:0]      wrHit;     // bus write reaches this pair's byte
  logic [NP-1:0][7:0] wrByte;    // written byte for this pair
  logic [NP-1:0]      pickOne;   // pair chosen for next conversion
  logic [4:0]         pickInput; // its lower analog input
  logic               wrFire;    // address and data both held

  // compose one pair's readable byte
  function automatic logic [7:0] pair_byte(input int p);
    pair_byte = {irqEn_ff[p], pend_ff[p], soft_ff[p], trigSrc_ff[p]};
  endfunction

  // read data for an address, zero for unmapped
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    read_word = 32'h0000_0000;
    if (addr == adcpt_pkg::REG_CTRL1_ADDR) begin
      read_word[15:0] = {p3Byte_ff, pair_byte(0)};
    end else if (addr == adcpt_pkg::REG_CTRL2_ADDR) begin
      read_word[15:0] = {pair_byte(2), pair_byte(1)};
    end else if (addr == adcpt_pkg::REG_STAT_ADDR) begin
      read_word[adcpt_pkg::STAT_FLIGHT_LSB +: NP] = inFlight_ff;
      read_word[adcpt_pkg::STAT_BUSY]             = coreBusy;
    end
  endfunction

  // address decode shared by read and write responses
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == adcpt_pkg::REG_CTRL1_ADDR) ||
                  (addr == adcpt_pkg::REG_CTRL2_ADDR) ||
                  (addr == adcpt_pkg::REG_STAT_ADDR);
  endfunction

  // ready outputs are combinational, valid, response and data from flops
  assign awready        = ~awHeld_ff & ~bvalid_ff;
  assign wready         = ~wHeld_ff & ~bvalid_ff;
  assign arready        = ~rvalid_ff;
  assign bvalid         = bvalid_ff;
  assign bresp          = bresp_ff;
  assign rvalid         = rvalid_ff;
  assign rdata          = rdata_ff;
  assign rresp          = rresp_ff;
  assign convStart      = convStart_ff;
  assign convFirstInput = convInput_ff;
  assign convPairSel    = inFlight_ff;
  assign pairIrq        = irq_ff;
  // write executes one cycle after both halves are held
  assign wrFire         = awHeld_ff & wHeld_ff & ~bvalid_ff;

  // per-pair trigger selection and write decode
  for (genvar p = 0; p < NP; p++) begin : g_pair
    localparam logic [7:0] RA = adcpt_pkg::pair_reg_addr(p);
    localparam int         LN = adcpt_pkg::pair_lane(p);

    assign wrByte[p] = wData_ff[LN*adcpt_pkg::LANE_W +: 8];
    assign wrHit[p]  = wrFire && (awAddr_ff == RA) && wStrb_ff[LN];
    assign doneThis[p] = coreDone && inFlight_ff[p] && (state_ff == adcpt_pkg::CONV_RUN);
    // a trigger on an already pending pair is dropped unless it just finished
    assign setPend[p]  = trigHit[p] && (!pend_ff[p] || doneThis[p]);

    adcpt_trig_select u_sel (
      .trigSrc          (trigSrc_ff[p]),
      .softTrig         (soft_ff[p]),
      .globalSoftTrig   (globalSoftTrig),
      .pwmSpecialEvt    (pwmSpecialEvt),
      .pwmSecSpecialEvt (pwmSecSpecialEvt),
      .pwmPrimaryTrig   (pwmPrimaryTrig),
      .pwmSecondaryTrig (pwmSecondaryTrig),
      .pwmCurLimTrig    (pwmCurLimTrig),
      .firstTimerMatch  (firstTimerMatch),
      .secondTimerMatch (secondTimerMatch),
      .trigHit          (trigHit[p])
    );

    // pending sets on its trigger
    a_pend_set: assert property (@(posedge mclk) disable iff (rst)
      trigHit[p] && !pend_ff[p] |=> pend_ff[p])
      else $error("pending flag did not set on trigger");

    // pending holds until its own conversion completes
    a_pend_hold: assert property (@(posedge mclk) disable iff (rst)
      pend_ff[p] && !doneThis[p] |=> pend_ff[p]
        && (inFlight_ff[p] || !$past(inFlight_ff[p])))
      else $error("pending flag dropped before completion");

    // completion without retrigger clears pending
    a_pend_clear: assert property (@(posedge mclk) disable iff (rst)
      doneThis[p] && !trigHit[p] |=> !pend_ff[p])
      else $error("pending flag not cleared after completion");

    // soft bit clears as pending sets, unless rewritten that cycle
    a_soft_clear: assert property (@(posedge mclk) disable iff (rst)
      setPend[p] && !wrHit[p] |=> !soft_ff[p])
      else $error("soft trigger bit not cleared by hardware");

    // request follows completion only when enabled
    a_irq_done: assert property (@(posedge mclk) disable iff (rst)
      doneThis[p] |=> irq_ff[p] == $past(irqEn_ff[p]))
      else $error("completion request wrong for enable setting");

    // a request never appears without a completion
    a_irq_cause: assert property (@(posedge mclk) disable iff (rst)
      irq_ff[p] |-> $past(doneThis[p]) && !$stable(irq_ff[p]) ##1 !irq_ff[p]
        || $past(doneThis[p]))
      else $error("completion request without completion");

    // disabled selector never starts a conversion
    a_src_off: assert property (@(posedge mclk) disable iff (rst)
      trigSrc_ff[p] == adcpt_pkg::SRC_OFF && !pend_ff[p] |=> !pend_ff[p])
      else $error("disabled selector set pending");
  end

  // pair control registers: bus writes and hardware set/clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqEn_ff   <= '0;
      pend_ff    <= '0;
      soft_ff    <= '0;
      trigSrc_ff <= '0;
      p3Byte_ff  <= adcpt_pkg::PAIR_BYTE_RESET;
    end else begin
      for (int p = 0; p < NP; p++) begin
        // set wins over completion in the same cycle
        pend_ff[p] <= setPend[p] | (pend_ff[p] & ~doneThis[p]);
        if (wrHit[p]) begin
          // pending is status only; bus writes to it are ignored
          irqEn_ff[p]   <= wrByte[p][adcpt_pkg::FLD_IRQEN];
          trigSrc_ff[p] <= wrByte[p][adcpt_pkg::FLD_SRC_LSB +: adcpt_pkg::SRC_W];
          soft_ff[p]    <= wrByte[p][adcpt_pkg::FLD_SOFT];
        end else if (setPend[p]) begin
          soft_ff[p] <= 1'b0;
        end
      end
      // pair 3 byte only stored so the shared register reads back
      if (wrFire && awAddr_ff == adcpt_pkg::REG_CTRL1_ADDR && wStrb_ff[1]) begin
        p3Byte_ff <= wData_ff[15:8];
      end
    end
  end

  // pick lowest-numbered waiting pair
  always_comb begin
    pickOne   = '0;
    pickInput = 5'h00;
    for (int p = NP - 1; p >= 0; p--) begin
      if (pend_ff[p]) begin
        pickOne   = '0;
        pickOne[p] = 1'b1;
        pickInput = adcpt_pkg::pair_first_input(p);
      end
    end
  end

  // sequencer: one conversion at a time, wait for a free core
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff     <= adcpt_pkg::CONV_IDLE;
      inFlight_ff  <= '0;
      convStart_ff <= 1'b0;
      convInput_ff <= 5'h00;
    end else begin
      convStart_ff <= 1'b0;
      case (state_ff)
        adcpt_pkg::CONV_IDLE: begin
          // busy core holds the request until resources free
          if (!coreBusy && |pend_ff) begin
            state_ff     <= adcpt_pkg::CONV_RUN;
            inFlight_ff  <= pickOne;
            convStart_ff <= 1'b1;
            convInput_ff <= pickInput;
          end
        end
        adcpt_pkg::CONV_RUN: begin
          if (coreDone) begin
            state_ff    <= adcpt_pkg::CONV_IDLE;
            inFlight_ff <= '0;
          end
        end
        default: begin
          state_ff <= adcpt_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // completion request pulses, gated by enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_ff <= '0;
    end else begin
      irq_ff <= doneThis & irqEn_ff;
    end
  end

  // write address and data capture, in either order
  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end else if (wrFire) begin
        awHeld_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end else if (wrFire) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge mclk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= adcpt_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= addr_mapped(awAddr_ff) ? adcpt_pkg::RESP_OKAY : adcpt_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read channel: data one cycle after address
  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= adcpt_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= read_word(araddr);
      rresp_ff  <= addr_mapped(araddr) ? adcpt_pkg::RESP_OKAY : adcpt_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // start is only issued while the core was free
  a_start_free: assert property (@(posedge mclk) disable iff (rst)
    convStart_ff |-> !$past(coreBusy) && $past(state_ff) == adcpt_pkg::CONV_IDLE)
    else $error("conversion started while core busy");

  // at most one pair converts at once, and start names it
  a_one_flight: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(inFlight_ff) && (convStart_ff -> $onehot(inFlight_ff)))
    else $error("more than one pair in flight");

  // reset clears every control bit
  a_reset_zero: assert property (@(posedge mclk)
    rst |=> irqEn_ff == '0 && pend_ff == '0 && soft_ff == '0 && trigSrc_ff == '0)
    else $error("control bits not zero after reset");

endmodule

//--- common/adcpt_pkg.sv
// shared constants for the converter pair trigger control block
package adcpt_pkg;

  // pairs handled here: index 0 = pair 2, index 1 = pair 4, index 2 = pair 5
  localparam int NPAIR  = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] REG_CTRL1_ADDR = 8'h00;  // pair 2 low byte, pair 3 high byte
  localparam logic [7:0] REG_CTRL2_ADDR = 8'h04;  // pair 4 low byte, pair 5 high byte
  localparam logic [7:0] REG_STAT_ADDR  = 8'h08;  // sequencer status, read only

  // reset values
  localparam logic [7:0] PAIR_BYTE_RESET = 8'h00;
  localparam logic [4:0] SRC_RESET       = 5'h00;

  // field positions inside one pair byte
  localparam int FLD_IRQEN   = 7;
  localparam int FLD_PEND    = 6;
  localparam int FLD_SOFT    = 5;
  localparam int FLD_SRC_LSB = 0;
  localparam int SRC_W       = 5;
  localparam int LANE_W      = 8;

  // status register field positions
  localparam int STAT_FLIGHT_LSB = 0;
  localparam int STAT_BUSY       = 3;

  // trigger source selector encodings
  localparam logic [4:0] SRC_OFF         = 5'h00;
  localparam logic [4:0] SRC_INDIV_SW    = 5'h01;
  localparam logic [4:0] SRC_GLOBAL_SW   = 5'h02;
  localparam logic [4:0] SRC_SPECIAL     = 5'h03;
  localparam logic [4:0] SRC_PRI_FIRST   = 5'h04;
  localparam logic [4:0] SRC_PRI_LAST    = 5'h0B;
  localparam logic [4:0] SRC_TMR_FIRST   = 5'h0C;
  localparam logic [4:0] SRC_SEC_SPECIAL = 5'h0D;
  localparam logic [4:0] SRC_SEC_FIRST   = 5'h0E;
  localparam logic [4:0] SRC_SEC_LAST    = 5'h16;
  localparam logic [4:0] SRC_CLIM_FIRST  = 5'h17;
  localparam logic [4:0] SRC_CLIM_LAST   = 5'h1E;
  localparam logic [4:0] SRC_TMR_SECOND  = 5'h1F;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // conversion sequencer states
  typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} adcpt_conv_t;

  // register that holds a pair's control byte
  function automatic logic [7:0] pair_reg_addr(input int p);
    pair_reg_addr = (p == 0) ? REG_CTRL1_ADDR : REG_CTRL2_ADDR;
  endfunction

  // byte lane of a pair within its register
  function automatic int pair_lane(input int p);
    pair_lane = (p == 2) ? 1 : 0;
  endfunction

  // lower analog input of a pair; the upper one is this plus one
  function automatic logic [4:0] pair_first_input(input int p);
    pair_first_input = (p == 0) ? 5'h04 : ((p == 1) ? 5'h08 : 5'h0A);
  endfunction

endpackage

//--- rtl/adcpt_trig_select.sv
// trigger source multiplexer for one converter pair
module adcpt_trig_select (
  // selector and software sources
  input  wire logic [4:0] trigSrc,
  input  wire logic       softTrig,
  input  wire logic       globalSoftTrig,
  // pwm and timer sources
  input  wire logic       pwmSpecialEvt,
  input  wire logic       pwmSecSpecialEvt,
  input  wire logic [7:0] pwmPrimaryTrig,
  input  wire logic [8:0] pwmSecondaryTrig,
  input  wire logic [7:0] pwmCurLimTrig,
  input  wire logic       firstTimerMatch,
  input  wire logic       secondTimerMatch,
  // selected trigger
  output logic            trigHit
);

  logic [4:0] relIdx;  // offset of selector inside its generator range

  // one selector picks one source, except 00010 which also takes the soft bit; 00000 picks nothing
  always_comb begin
    relIdx  = 5'h00;
    trigHit = 1'b0;
    if (trigSrc == adcpt_pkg::SRC_OFF) begin
      trigHit = 1'b0;
    end else if (trigSrc == adcpt_pkg::SRC_INDIV_SW) begin
      trigHit = softTrig;
    end else if (trigSrc == adcpt_pkg::SRC_GLOBAL_SW) begin
      // soft bit still counts here, as software is told to pick this mode
      trigHit = softTrig | globalSoftTrig;
    end else if (trigSrc == adcpt_pkg::SRC_SPECIAL) begin
      trigHit = pwmSpecialEvt;
    end else if (trigSrc == adcpt_pkg::SRC_SEC_SPECIAL) begin
      trigHit = pwmSecSpecialEvt;
    end else if (trigSrc <= adcpt_pkg::SRC_PRI_LAST) begin
      relIdx  = trigSrc - adcpt_pkg::SRC_PRI_FIRST;
      trigHit = pwmPrimaryTrig[relIdx[2:0]];
    end else if (trigSrc == adcpt_pkg::SRC_TMR_FIRST) begin
      trigHit = firstTimerMatch;
    end else if (trigSrc <= adcpt_pkg::SRC_SEC_LAST) begin
      relIdx  = trigSrc - adcpt_pkg::SRC_SEC_FIRST;
      trigHit = pwmSecondaryTrig[relIdx[3:0]];
    end else if (trigSrc <= adcpt_pkg::SRC_CLIM_LAST) begin
      relIdx  = trigSrc - adcpt_pkg::SRC_CLIM_FIRST;
      trigHit = pwmCurLimTrig[relIdx[2:0]];
    end else begin
      trigHit = secondTimerMatch;
    end
  end

endmodule

//--- dv/adcpt_core_model.sv
// converter core stand-in: answers each start with one done pulse
module adcpt_core_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // bench controls
  input  wire logic       othersBusy,
  input  wire logic [3:0] latency,
  // block side
  input  wire logic       convStart,
  output logic            coreBusy,
  output logic            coreDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_ff;  // cycles left in this conversion
  logic       run_ff;   // conversion in flight
  // converter held by other channels, the block must wait
  assign coreBusy = othersBusy;
  // one done per start; latency is sampled at start so a slow answer can be forced
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_ff   <= 1'b0;
      left_ff  <= 4'h0;
      coreDone <= 1'b0;
    end else begin
      coreDone <= 1'b0;
      if (convStart) begin
        run_ff  <= 1'b1;
        left_ff <= latency;
      end else if (run_ff && left_ff == 4'h0) begin
        run_ff   <= 1'b0;
        coreDone <= 1'b1;
      end else if (run_ff) begin
        left_ff <= left_ff - 4'h1;
      end
    end
  end
endmodule

//--- dv/adc_pair_trigger_control_bench.sv
// self-checking bench for the converter pair trigger control block
module adc_pair_trigger_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;  // well above the whole run
  // bus
  logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, latency;
  logic [1:0]  bresp, rresp;
  // triggers: 0 global, 1 special, 2 second special, 3-10 primary,
  // 11-19 secondary, 20-27 current limit, 28 first timer, 29 second timer
  logic [29:0] trig;
  logic        busy, done, start, othersBusy;
  logic [4:0]  firstIn;
  logic [2:0]  pairSel, pairIrq;
  int          err_total, total_checks, starts, cyc;
  int          irqN[3];
  int          firstTab[3] = '{4, 8, 10};  // lower input of each pair
  int          expQ[$];                    // pairs expected to start, in order

  adcpt_pair_ctrl i_dut (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .globalSoftTrig(trig[0]), .pwmSpecialEvt(trig[1]), .pwmSecSpecialEvt(trig[2]),
    .pwmPrimaryTrig(trig[10:3]), .pwmSecondaryTrig(trig[19:11]),
    .pwmCurLimTrig(trig[27:20]), .firstTimerMatch(trig[28]),
    .secondTimerMatch(trig[29]), .coreBusy(busy), .coreDone(done), .convStart(start),
    .convFirstInput(firstIn), .convPairSel(pairSel), .pairIrq(pairIrq));

  adcpt_core_model i_core (
    .mclk(mclk), .rst(rst), .othersBusy(othersBusy), .latency(latency),
    .convStart(start), .coreBusy(busy), .coreDone(done));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // event counters and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      starts <= starts + 1;
      chk("start pair", expQ.size() ? 32'h1 << expQ.pop_front() : 32'h0, pairSel);
    end
    for (int i = 0; i < 3; i++)
      if (pairIrq[i] === 1'b1)
        irqN[i] <= irqN[i] + 1;
    if (cyc == LIMIT) begin
      err_total++;
      complete_run();
    end
  end

  // trigger line that each selector code should pick
  function automatic int src_bit(input logic [4:0] s);
    if (s == 5'h03) return 1;
    if (s == 5'h0D) return 2;
    if (s == 5'h0C) return 28;
    if (s == 5'h1F) return 29;
    if (s >= 5'h04 && s <= 5'h0B) return int'(s) - 1;
    if (s >= 5'h0E && s <= 5'h16) return int'(s) - 3;
    if (s >= 5'h17 && s <= 5'h1E) return int'(s) - 3;
    return 0;  // global soft line
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] m,
                    output logic [1:0] r);
    bit ta, tw, ga, gw;
    ga = 0;
    gw = 0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= m;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ga && gw)) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      ga |= ta;
      gw |= tw;
    end
    do @(negedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask

  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit t;
    t = 0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!t) begin
      @(negedge mclk);
      t = arvalid && arready;
      @(posedge mclk);
      if (t)
        arvalid <= 1'b0;
    end
    do @(negedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask

  // one-cycle pulse on chosen trigger lines
  task automatic pulse(input logic [29:0] v);
    @(posedge mclk);
    trig <= v;
    @(posedge mclk);
    trig <= 30'h0;
  endtask

  task automatic wait_start;
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (start !== 1'b1 && n < 40);
    chk("start seen", 32'h1, {31'h0, start});
  endtask

  // extra cycles let the completion pulse reach the counters
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pairSel !== 3'h0 && n < 40);
    repeat (2) @(negedge mclk);
  endtask

  // stray line first, then the selected one, through a whole conversion
  task automatic conv(input int p, input logic [4:0] s, input logic ie);
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  m;
    int          sh, n, k, wb;
    a  = (p == 0) ? adcpt_pkg::REG_CTRL1_ADDR : adcpt_pkg::REG_CTRL2_ADDR;
    sh = (p == 2) ? 8 : 0;
    m  = (p == 2) ? 4'h2 : 4'h1;
    k  = src_bit(s);
    wb = (k + 1 + int'($urandom % 29)) % 30;
    wr(a, {24'h0, ie, 2'b00, s} << sh, m, r);
    chk("write resp", {30'h0, adcpt_pkg::RESP_OKAY}, {30'h0, r});
    latency <= 4'h6 + 4'($urandom % 8);
    n = starts;
    pulse(30'h1 << wb);
    repeat (4) @(negedge mclk);
    chk("stray start", n, starts);
    expQ.push_back(p);
    if (s == adcpt_pkg::SRC_INDIV_SW)
      wr(a, {24'h0, ie, 2'b01, s} << sh, m, r);
    else
      pulse(30'h1 << k);
    n = irqN[p];
    wait_start();
    chk("first input", firstTab[p], firstIn);
    chk("pair select", 32'h1 << p, pairSel);
    rd(a, d, r);
    chk("pending soft", 32'h2, (d >> (sh + 5)) & 32'h3);
    rd(adcpt_pkg::REG_STAT_ADDR, d, r);
    chk("status in flight", 32'h1 << p, d);
    wait_idle();
    chk("irq count", n + ie, irqN[p]);
    rd(a, d, r);
    chk("pending clear", 32'h0, (d >> (sh + 6)) & 32'h1);
    wr(a, 32'h0, m, r);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    {rst, awvalid, wvalid, bready, arvalid, rready, othersBusy} = 7'h7F & 7'h40;
    {awaddr, araddr, wdata, wstrb, trig} = '0;
    latency = 4'h8;
    err_total = 0;
    total_checks = 0;
    starts = 0;
    cyc = 0;
    irqN = '{0, 0, 0};
    d = $urandom(16);
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(adcpt_pkg::REG_CTRL1_ADDR, d, r);
    chk("ctrl1 reset", 32'h0, d);
    rd(adcpt_pkg::REG_CTRL2_ADDR, d, r);
    chk("ctrl2 reset", 32'h0, d);
    wr(adcpt_pkg::REG_CTRL1_ADDR, 32'h0000FF00, 4'h2, r);
    rd(adcpt_pkg::REG_CTRL1_ADDR, d, r);
    chk("upper byte storage", 32'h0000FF00, d);
    wr(adcpt_pkg::REG_CTRL2_ADDR, 32'h0000C000, 4'h2, r);
    rd(adcpt_pkg::REG_CTRL2_ADDR, d, r);
    chk("pending read only", 32'h00008000, d);
    wr(8'h10, 32'h0000FFFF, 4'h3, r);
    chk("unmapped write", {30'h0, adcpt_pkg::RESP_SLVERR}, {30'h0, r});
    rd(8'h10, d, r);
    chk("unmapped read", {30'h0, adcpt_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(adcpt_pkg::REG_CTRL1_ADDR, 32'h0, 4'h3, r);
    wr(adcpt_pkg::REG_CTRL2_ADDR, 32'h0, 4'h3, r);
    // selector off: every line at once starts nothing
    n = starts;
    pulse(30'h3FFFFFFF);
    repeat (4) @(negedge mclk);
    chk("off selector", n, starts);
    for (int s = 1; s < 32; s++)
      conv(s % 3, 5'(s), 1'($urandom));
    // two pairs fire while the converter is taken; a second pulse on each is dropped while pending
    wr(adcpt_pkg::REG_CTRL1_ADDR, 32'h00000003, 4'h1, r);
    wr(adcpt_pkg::REG_CTRL2_ADDR, 32'h00000300, 4'h2, r);
    n = starts;
    expQ.push_back(0);
    expQ.push_back(2);
    othersBusy <= 1'b1;
    pulse(30'h2);
    pulse(30'h2);
    repeat (6) @(negedge mclk);
    chk("held while busy", n, starts);
    @(posedge mclk);
    othersBusy <= 1'b0;
    wait_start();
    chk("first of two", 32'h1, pairSel);
    wait_start();
    chk("second of two", 32'h4, pairSel);
    wait_idle();
    chk("one start each", n + 2, starts);
    complete_run();
  end
endmodule
